/* design/dram_refresh_wait_ctrl.sv */
// Functional notes
// - Refresh only while refresh_enable set; reset sets it.
// - Refresh lasts two clocks, three with wait.
// - Interval select gives 10/20/40/80 states.
// - After reset: every 10 clocks, 3 long.
// - No refresh in reset, grant, sleep, wait.
// - Interval timer keeps counting during bus grant.
// - Sleep request latched, served after sleep ends.
// - Later refreshes follow the timer alone.
// - Address advances once per performed refresh.
// - Memory wait field adds 0 to 3.
// - I/O wait field adds 1 to 4.
// - I/O waits extend the 3-clock cycle.
`timescale 1ns/1ps
`default_nettype none

module dram_refresh_wait_ctrl (
  // Clock and reset.
  input  wire logic                            core_clk,
  input  wire logic                            rst_n,
  // Internal I/O register port.
  input  wire refresh_wait_pkg::reg_req_type   reg_req,
  output logic [7:0]                           reg_rdata,
  // Processor machine cycles.
  input  wire refresh_wait_pkg::cpu_cycle_type cpu_cycle,
  // Bus ownership and stall conditions.
  input  wire refresh_wait_pkg::bus_status_type bus_status,
  // Wait request towards the processor and DMA unit.
  output logic                                 wait_request,
  // Refresh cycle outputs.
  output logic                                 refresh_active,
  output logic                                 refresh_extra_wait_state,
  output logic [7:0]                           refresh_addr
);

  // Whole block state in one record.
  typedef struct packed {
    refresh_wait_pkg::refresh_state_type state;
    logic                                pending;
    logic                                long_cycle;
    logic [1:0]                          len_left;
    logic                                active;
    logic                                extra_wait;
    logic [7:0]                          addr;
    logic                                refresh_enable;
    logic                                refresh_wait_select;
    logic [1:0]                          refresh_interval_select;
    logic [1:0]                          memory_wait_count;
    logic [1:0]                          io_wait_count;
    logic [3:0]                          dma_fields;
    logic [7:0]                          rdata;
  } ctrl_state_type;

  ctrl_state_type cur;
  ctrl_state_type next_cur;

  logic       refresh_tick;
  logic       wait_active;
  logic       hit_wait_reg;
  logic       hit_refresh_reg;
  logic       may_start;
  logic [2:0] access_wait_count;

  // Interval timer that raises a request every selected number of states.
  refresh_interval_timer u_interval_timer (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .interval_select (cur.refresh_interval_select),
    .refresh_tick    (refresh_tick)
  );

  // Wait states for the access that begins now.
  assign access_wait_count = refresh_wait_pkg::access_waits(cpu_cycle.access_is_io,
                                                            cur.memory_wait_count,
                                                            cur.io_wait_count);

  // Counter that stretches memory and I/O accesses.
  wait_state_counter u_wait_counter (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .load        (cpu_cycle.access_start),
    .wait_count  (access_wait_count),
    .wait_active (wait_active)
  );

  // Register address decode.
  assign hit_wait_reg    = (reg_req.addr == refresh_wait_pkg::WAIT_AND_DMA_CONTROL_OFFSET);
  assign hit_refresh_reg = (reg_req.addr == refresh_wait_pkg::REFRESH_CONTROL_OFFSET);

  // A refresh may begin only at a boundary while the processor owns the bus and runs.
  assign may_start = cpu_cycle.machine_cycle_end
                   & ~bus_status.external_bus_grant
                   & ~bus_status.sleep_mode
                   & ~bus_status.external_wait
                   & ~wait_active;

  // Register writes and read-back data.
  always_comb begin
    next_cur = cur;

    // Software writes to the control registers.
    if (reg_req.write && hit_refresh_reg) begin
      next_cur.refresh_enable          = reg_req.wdata[refresh_wait_pkg::REFRESH_ENABLE_BIT];
      next_cur.refresh_wait_select     = reg_req.wdata[refresh_wait_pkg::REFRESH_WAIT_SELECT_BIT];
      next_cur.refresh_interval_select =
        reg_req.wdata[refresh_wait_pkg::REFRESH_INTERVAL_LSB +: 2];
    end
    if (reg_req.write && hit_wait_reg) begin
      next_cur.memory_wait_count = reg_req.wdata[refresh_wait_pkg::MEMORY_WAIT_LSB +: 2];
      next_cur.io_wait_count     = reg_req.wdata[refresh_wait_pkg::IO_WAIT_LSB +: 2];
      next_cur.dma_fields        = reg_req.wdata[refresh_wait_pkg::DMA_FIELDS_LSB +: 4];
    end

    // Read data is registered one clock after the read strobe; other addresses read zero.
    next_cur.rdata = 8'h00;
    if (reg_req.read && hit_refresh_reg) begin
      next_cur.rdata[refresh_wait_pkg::REFRESH_ENABLE_BIT]      = cur.refresh_enable;
      next_cur.rdata[refresh_wait_pkg::REFRESH_WAIT_SELECT_BIT] = cur.refresh_wait_select;
      next_cur.rdata[refresh_wait_pkg::REFRESH_INTERVAL_LSB +: 2] = cur.refresh_interval_select;
    end else if (reg_req.read && hit_wait_reg) begin
      next_cur.rdata[refresh_wait_pkg::MEMORY_WAIT_LSB +: 2] = cur.memory_wait_count;
      next_cur.rdata[refresh_wait_pkg::IO_WAIT_LSB +: 2]     = cur.io_wait_count;
      next_cur.rdata[refresh_wait_pkg::DMA_FIELDS_LSB +: 4]  = cur.dma_fields;
    end

    // Refresh sequencer.
    unique case (cur.state)
      refresh_wait_pkg::REFRESH_IDLE: begin
        next_cur.active     = 1'b0;
        next_cur.extra_wait = 1'b0;
        if (cur.pending && cur.refresh_enable && may_start) begin
          next_cur.state      = refresh_wait_pkg::REFRESH_BUSY;
          next_cur.pending    = 1'b0;
          next_cur.active     = 1'b1;
          next_cur.long_cycle = cur.refresh_wait_select;
          next_cur.len_left   = cur.refresh_wait_select ? refresh_wait_pkg::REFRESH_LONG_LAST
                                                        : refresh_wait_pkg::REFRESH_SHORT_LAST;
        end
      end
      refresh_wait_pkg::REFRESH_BUSY: begin
        if (cur.len_left == 2'd0) begin
          // Cycle done: the next refresh uses the following row.
          next_cur.state      = refresh_wait_pkg::REFRESH_IDLE;
          next_cur.active     = 1'b0;
          next_cur.extra_wait = 1'b0;
          next_cur.addr       = cur.addr + 8'h01;
        end else begin
          next_cur.len_left   = cur.len_left - 2'd1;
          next_cur.extra_wait = cur.long_cycle && (cur.len_left == 2'd1);
        end
      end
    endcase

    // A new request overwrites any held one; it wins over the clear at start.
    if (refresh_tick) begin
      next_cur.pending = 1'b1;
    end

    // Disabled refresh drops any held request.
    if (!next_cur.refresh_enable) begin
      next_cur.pending = 1'b0;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur.state                   <= refresh_wait_pkg::REFRESH_IDLE;
      cur.pending                 <= 1'b0;
      cur.long_cycle              <= 1'b0;
      cur.len_left                <= 2'd0;
      cur.active                  <= 1'b0;
      cur.extra_wait              <= 1'b0;
      cur.addr                    <= refresh_wait_pkg::REFRESH_ADDR_RESET;
      cur.refresh_enable          <= refresh_wait_pkg::REFRESH_ENABLE_RESET;
      cur.refresh_wait_select     <= refresh_wait_pkg::REFRESH_WAIT_SELECT_RESET;
      cur.refresh_interval_select <= refresh_wait_pkg::REFRESH_INTERVAL_RESET;
      cur.memory_wait_count       <= refresh_wait_pkg::MEMORY_WAIT_RESET;
      cur.io_wait_count           <= refresh_wait_pkg::IO_WAIT_RESET;
      cur.dma_fields              <= refresh_wait_pkg::DMA_FIELDS_RESET;
      cur.rdata                   <= 8'h00;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from flip-flops.
  assign reg_rdata                = cur.rdata;
  assign wait_request             = wait_active;
  assign refresh_active           = cur.active;
  assign refresh_extra_wait_state = cur.extra_wait;
  assign refresh_addr             = cur.addr;

endmodule

`default_nettype wire

/* design/refresh_interval_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module refresh_interval_timer (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Interval control.
  input  wire logic [1:0] interval_select,
  // Request pulse.
  output logic            refresh_tick
);

  typedef struct packed {
    logic [6:0] count;
    logic       tick;
  } timer_state_type;

  timer_state_type cur;
  timer_state_type next_cur;

  // Free-running count that wraps at the selected interval, even while the bus is away.
  always_comb begin
    next_cur      = cur;
    next_cur.tick = 1'b0;
    if (cur.count >= refresh_wait_pkg::interval_states(interval_select) - 7'd1) begin
      next_cur.count = 7'd0;
      next_cur.tick  = 1'b1;
    end else begin
      next_cur.count = cur.count + 7'd1;
    end
  end

  // Only reset stops the timer.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign refresh_tick = cur.tick;

endmodule

`default_nettype wire

/* design/wait_state_counter.sv */
`timescale 1ns/1ps
`default_nettype none

module wait_state_counter (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Load request.
  input  wire logic       load,
  input  wire logic [2:0] wait_count,
  // Wait output.
  output logic            wait_active
);

  typedef struct packed {
    logic [2:0] remaining;
    logic       busy;
  } wait_state_type;

  wait_state_type cur;
  wait_state_type next_cur;

  // Holds busy for exactly wait_count clocks after the load.
  always_comb begin
    next_cur = cur;
    if (load) begin
      next_cur.busy      = (wait_count != 3'd0);
      next_cur.remaining = (wait_count != 3'd0) ? wait_count - 3'd1 : 3'd0;
    end else if (cur.busy) begin
      if (cur.remaining == 3'd0) begin
        next_cur.busy = 1'b0;
      end else begin
        next_cur.remaining = cur.remaining - 3'd1;
      end
    end
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign wait_active = cur.busy;

endmodule

`default_nettype wire

/* include/refresh_wait_pkg.sv */
package refresh_wait_pkg;

  // Register offsets on the internal I/O port.
  localparam logic [7:0] WAIT_AND_DMA_CONTROL_OFFSET = 8'h32;
  localparam logic [7:0] REFRESH_CONTROL_OFFSET      = 8'h36;

  // Field positions of refresh_control.
  localparam int REFRESH_ENABLE_BIT       = 7;
  localparam int REFRESH_WAIT_SELECT_BIT  = 6;
  localparam int REFRESH_INTERVAL_LSB     = 0;

  // Field positions of wait_and_dma_control.
  localparam int MEMORY_WAIT_LSB          = 6;
  localparam int IO_WAIT_LSB              = 4;
  localparam int DMA_FIELDS_LSB           = 0;

  // Values after reset.
  localparam logic       REFRESH_ENABLE_RESET      = 1'b1;
  localparam logic       REFRESH_WAIT_SELECT_RESET = 1'b1;
  localparam logic [1:0] REFRESH_INTERVAL_RESET    = 2'h0;
  localparam logic [1:0] MEMORY_WAIT_RESET         = 2'h3;
  localparam logic [1:0] IO_WAIT_RESET             = 2'h3;
  localparam logic [3:0] DMA_FIELDS_RESET          = 4'h0;
  localparam logic [7:0] REFRESH_ADDR_RESET        = 8'h00;

  // Refresh insertion intervals in clock states.
  localparam logic [6:0] INTERVAL_STATES_0 = 7'd10;
  localparam logic [6:0] INTERVAL_STATES_1 = 7'd20;
  localparam logic [6:0] INTERVAL_STATES_2 = 7'd40;
  localparam logic [6:0] INTERVAL_STATES_3 = 7'd80;

  // Refresh cycle lengths in clocks, minus one as loaded into the length counter.
  localparam logic [1:0] REFRESH_SHORT_LAST = 2'd1;
  localparam logic [1:0] REFRESH_LONG_LAST  = 2'd2;

  // Extra I/O wait added on top of the coded field.
  localparam logic [2:0] IO_WAIT_BASE = 3'd1;

  // Software bound on refresh spacing and its cycle count at 50 MHz.
  localparam int CLK_PERIOD_PS         = 20000;
  localparam int REFRESH_LIMIT_PS      = 15625000;
  localparam int REFRESH_LIMIT_CYCLES  = REFRESH_LIMIT_PS / CLK_PERIOD_PS;

  // Refresh sequencer states.
  typedef enum logic [1:0] {
    REFRESH_IDLE = 2'b01,
    REFRESH_BUSY = 2'b10
  } refresh_state_type;

  // Register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       write;
    logic       read;
  } reg_req_type;

  // Processor machine cycle events.
  typedef struct packed {
    logic machine_cycle_end;
    logic access_start;
    logic access_is_io;
  } cpu_cycle_type;

  // Conditions that hold refresh off.
  typedef struct packed {
    logic external_bus_grant;
    logic sleep_mode;
    logic external_wait;
  } bus_status_type;

  // Decodes the interval select into clock states.
  function automatic logic [6:0] interval_states(input logic [1:0] sel);
    unique case (sel)
      2'h0: interval_states = INTERVAL_STATES_0;
      2'h1: interval_states = INTERVAL_STATES_1;
      2'h2: interval_states = INTERVAL_STATES_2;
      2'h3: interval_states = INTERVAL_STATES_3;
    endcase
  endfunction

  // Wait states for one access, memory or I/O.
  function automatic logic [2:0] access_waits(input logic is_io, input logic [1:0] mem_code,
                                              input logic [1:0] io_code);
    access_waits = is_io ? (IO_WAIT_BASE + {1'b0, io_code}) : {1'b0, mem_code};
  endfunction

endpackage

/* testbench/dram_refresh_wait_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module dram_refresh_wait_ctrl_sva (
  // Clock and reset.
  input wire logic                             core_clk,
  input wire logic                             rst_n,
  // Watched ports.
  input wire refresh_wait_pkg::reg_req_type    reg_req,
  input wire logic [7:0]                       reg_rdata,
  input wire refresh_wait_pkg::cpu_cycle_type  cpu_cycle,
  input wire refresh_wait_pkg::bus_status_type bus_status,
  input wire logic                             wait_request,
  input wire logic                             refresh_active,
  input wire logic                             refresh_extra_wait_state,
  input wire logic [7:0]                       refresh_addr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Body of one refresh: two clocks, the third only with the extra wait flag.
  sequence s_body;
    refresh_active[*2] ##1 (refresh_active == refresh_extra_wait_state) ##1 !refresh_active;
  endsequence
  sequence s_start;
    $rose(refresh_active);
  endsequence

  property p_free_start;
    s_start |-> $past(cpu_cycle.machine_cycle_end && bus_status == 3'b000);
  endproperty
  property p_no_wait_start;
    s_start |-> !$past(wait_request);
  endproperty
  property p_length;
    s_start |-> s_body;
  endproperty
  property p_addr_step;
    $past(rst_n) && $fell(refresh_active) |-> refresh_addr == $past(refresh_addr) + 8'h01;
  endproperty
  property p_addr_hold;
    $past(rst_n) && !$fell(refresh_active) |-> $stable(refresh_addr);
  endproperty
  property p_io_min;
    cpu_cycle.access_start && cpu_cycle.access_is_io |=> wait_request;
  endproperty
  property p_wait_max;
    (wait_request && !cpu_cycle.access_start)[*4] |=> !wait_request;
  endproperty
  property p_wait_cause;
    $rose(wait_request) |-> $past(cpu_cycle.access_start);
  endproperty

  a_free_start: assert property (p_free_start) else $error("refresh began off a free boundary");
  a_no_wait_start: assert property (p_no_wait_start) else $error("refresh began during wait");
  a_length: assert property (p_length) else $error("refresh length wrong");
  a_addr_step: assert property (p_addr_step) else $error("refresh address did not step");
  a_addr_hold: assert property (p_addr_hold) else $error("refresh address moved");
  a_io_min: assert property (p_io_min) else $error("io access without wait");
  a_wait_max: assert property (p_wait_max) else $error("wait longer than four");
  a_wait_cause: assert property (p_wait_cause) else $error("wait without access");
endmodule

bind dram_refresh_wait_ctrl dram_refresh_wait_ctrl_sva i_dram_refresh_wait_ctrl_sva (
  .core_clk, .rst_n, .reg_req, .reg_rdata, .cpu_cycle, .bus_status, .wait_request,
  .refresh_active, .refresh_extra_wait_state, .refresh_addr);

`default_nettype wire

/* testbench/dram_refresh_wait_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(w, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %0h seen %0h", w, e, g); end end

module dram_refresh_wait_ctrl_test;
  logic                             core_clk;
  logic                             rst_n;
  refresh_wait_pkg::reg_req_type    reg_req;
  logic [7:0]                       reg_rdata;
  refresh_wait_pkg::cpu_cycle_type  cpu_cycle;
  refresh_wait_pkg::bus_status_type bus_status;
  logic                             wait_request;
  logic                             refresh_active;
  logic                             refresh_extra_wait_state;
  logic [7:0]                       refresh_addr;
  logic [7:0]                       rows_done;
  logic [31:0]                      worst_gap;
  logic [7:0]                       a0;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rise_at;
  int len;
  int gap;
  int grid;
  int hits;
  // Rows: io flag, field code, expected wait clocks.
  logic [5:0] rows [8] = '{6'h00, 6'h09, 6'h12, 6'h1b, 6'h21, 6'h2a, 6'h33, 6'h3c};

  dram_refresh_wait_ctrl i_dram_refresh_wait_ctrl (.core_clk, .rst_n, .reg_req, .reg_rdata,
    .cpu_cycle, .bus_status, .wait_request, .refresh_active, .refresh_extra_wait_state, .refresh_addr);
  dram_row_model i_dram_row_model (.core_clk, .rst_n, .refresh_active, .refresh_addr, .rows_done, .worst_gap);

  // Clock of 20 ns.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Cycle count; a hang is cut short here.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tick();
    @(posedge core_clk);
    #2;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (16) tick();
    rst_n = 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.write = 1'b1;
    tick();
    reg_req.write = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_req.addr = a;
    reg_req.read = 1'b1;
    tick();
    `CHK("read data", e, reg_rdata)
    reg_req.read = 1'b0;
    tick();
  endtask

  // Finds the next refresh, its length and the spacing to the one after.
  task automatic meas();
    int k;
    k = 0;
    while (refresh_active !== 1'b1 && k < 300) begin tick(); k++; end
    rise_at = cyc;
    len = 0;
    while (refresh_active === 1'b1 && len < 9) begin tick(); len++; end
    gap = len;
    while (refresh_active !== 1'b1 && gap < 300) begin tick(); gap++; end
  endtask

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    reg_req = '0;
    cpu_cycle = '0;
    bus_status = '0;
    do_reset();
    wr(8'h36, 8'h00);
    foreach (rows[i]) begin
      wr(8'h32, {rows[i][4:3], rows[i][4:3], 4'h0});
      cpu_cycle.access_is_io = rows[i][5];
      cpu_cycle.access_start = 1'b1;
      tick();
      cpu_cycle.access_start = 1'b0;
      hits = 0;
      while (wait_request === 1'b1 && hits < 8) begin tick(); hits++; end
      `CHK("wait clocks", rows[i][2:0], hits)
    end
    rd(8'h40, 8'h00);
    do_reset();
    rd(8'h36, 8'hc0);
    rd(8'h32, 8'hf0);
    cpu_cycle.machine_cycle_end = 1'b1;
    meas();
    `CHK("default length", 3, len)
    `CHK("default spacing", 10, gap)
    for (int s = 0; s < 4; s++) begin
      wr(8'h36, 8'h80 | 8'(s));
      meas();
      meas();
      `CHK("spacing", 10 << s, gap)
      `CHK("short length", 2, len)
    end
    while (refresh_active === 1'b1) tick();
    wr(8'h36, 8'h00);
    a0 = refresh_addr;
    hits = 0;
    repeat (100) begin tick(); if (refresh_active === 1'b1) hits++; end
    `CHK("disabled refreshes", 0, hits)
    `CHK("disabled address", a0, refresh_addr)
    wr(8'h36, 8'h80);
    for (int k = 0; k < 4; k++) begin
      meas();
      grid = rise_at;
      while (refresh_active === 1'b1) tick();
      a0 = refresh_addr;
      if (k < 3) bus_status = refresh_wait_pkg::bus_status_type'(3'b100 >> k);
      else cpu_cycle.machine_cycle_end = 1'b0;
      hits = 0;
      repeat (31) begin tick(); if (refresh_active === 1'b1) hits++; end
      bus_status = '0;
      cpu_cycle.machine_cycle_end = 1'b1;
      meas();
      `CHK("blocked refreshes", 0, hits)
      `CHK("one refresh after block", a0 + 8'h01, refresh_addr)
      `CHK("timer phase", 0, (rise_at + gap - grid) % 10)
    end
    `CHK("rows refreshed", rows_done, refresh_addr)
    `CHK("pause within bound", 1'b1, worst_gap <= refresh_wait_pkg::REFRESH_LIMIT_CYCLES)
    conclude();
  end
endmodule

`default_nettype wire

/* testbench/dram_row_model.sv */
`timescale 1ns/1ps
`default_nettype none

module dram_row_model (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Refresh cycle from the controller.
  input wire logic        refresh_active,
  input wire logic [7:0]  refresh_addr,
  // Rows refreshed and longest pause seen.
  output logic [7:0]      rows_done,
  output logic [31:0]     worst_gap
);
  logic [31:0] gap;

  // Counts finished refreshes; a long pause would let rows decay.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rows_done <= 8'h00;
      gap <= 32'h0;
      worst_gap <= 32'h0;
    end else if (refresh_active) begin
      gap <= 32'h0;
    end else begin
      gap <= gap + 32'h1;
      if (gap > worst_gap) worst_gap <= gap;
    end
    if (rst_n && !refresh_active && $past(refresh_active)) rows_done <= rows_done + 8'h01;
  end
endmodule

`default_nettype wire
